/* File: pod_datapath.sv */
`timescale 1ns/1ps
module pod_datapath
  import pod_pkg::*;
#(
  parameter int WIDTH = POD_W,
  parameter int DEPTH = POD_NREG
) (
  input  wire logic        clock,
  input  wire logic        reset_n,
  input  wire pod_uword_t  uword,
  input  wire pod_cond_t   cond,
  output logic [15:0]      readBus,
  output logic [15:0]      aluResult,
  output logic [15:0]      bRegOut,
  output logic [15:0]      dRegOut,
  output logic             dCarryOut,
  output logic [15:0]      busAddress,
  output logic             accessError
);

  // elaboration check: logic is fixed at 16 bits, 16 entries
  if (WIDTH != POD_W || DEPTH != POD_NREG) begin : g_chk
    $error("pod_datapath supports only 16 bit width and 16 entries");
  end

  typedef struct packed {
    logic [15:0] bReg;
    logic [15:0] dReg;
    logic        dCarry;
    logic [15:0] addrReg;
    logic [15:0] readBus;
    logic [15:0] aluOut;
    logic        err;
  } pod_regs_t;

  pod_regs_t   st_q;
  pod_regs_t   st_d;
  logic [15:0] regFile_q [POD_NREG];

  logic [15:0] rfRead;
  logic [15:0] rdBus;
  logic [15:0] resultPath;
  logic [15:0] constantValue;
  logic [7:0]  opLow;
  logic [7:0]  opHigh;
  logic [15:0] aluSecondOperand;
  logic [15:0] aluFirstOperand;
  logic        aluCarryIn;
  logic [16:0] sumWord;
  logic [8:0]  sumByte;
  logic [15:0] aluRes;
  logic        wordCarryOut;
  logic        byteCarryOut;
  logic        aluResultMsb;
  logic        carrySel;
  logic        rfWriteOk;

  // read bus: wired-OR of register file and status word
  always_comb begin
    rfRead = (uword.regRead && !uword.regWrite) ? regFile_q[uword.regAddr] : 16'h0000;
    rdBus  = rfRead | (uword.statusRead ? cond.statusWord : 16'h0000);
  end

  assign aluFirstOperand = rdBus;

  // result path mux feeding the holding register
  always_comb begin
    case (uword.resultPathSel)
      POD_DM_RD:   resultPath = rdBus;
      POD_DM_BUS:  resultPath = cond.busData;
      POD_DM_DREG: resultPath = st_q.dReg;
      POD_DM_SHR:  resultPath = {st_q.dCarry, st_q.dReg[15:1]};
      default:     resultPath = rdBus;
    endcase
  end

  // constant source
  always_comb begin
    case (uword.constantSel)
      POD_K_ONE:   constantValue = POD_VAL_ONE;
      POD_K_TWO:   constantValue = POD_VAL_TWO;
      POD_K_SWADR: constantValue = cond.switchAddr;
      POD_K_TRAP:  constantValue = cond.trapVector;
      POD_K_MASK:  constantValue = POD_VAL_MASK;
      POD_K_COND:  constantValue = cond.condConst;
      POD_K_EXT:   constantValue = ~POD_VAL_MASK;
      POD_K_ZERO:  constantValue = 16'h0000;
      default:     constantValue = 16'h0000;
    endcase
  end

  // second operand byte muxes: direct, extend, duplicate, swap, constant
  always_comb begin
    case (uword.operandLowSel)
      POD_BL_LO0: opLow = st_q.bReg[7:0];
      POD_BL_LO1: opLow = st_q.bReg[7:0];
      POD_BL_HI:  opLow = st_q.bReg[15:8];
      POD_BL_CON: opLow = constantValue[7:0];
      default:    opLow = st_q.bReg[7:0];
    endcase
    case (uword.operandHighSel)
      POD_BH_HI:  opHigh = st_q.bReg[15:8];
      POD_BH_SGN: opHigh = {8{st_q.bReg[7]}};
      POD_BH_LO:  opHigh = st_q.bReg[7:0];
      POD_BH_CON: opHigh = constantValue[15:8];
      default:    opHigh = st_q.bReg[15:8];
    endcase
    aluSecondOperand = {opHigh, opLow};
  end

  // carry in from microword bits combined with a condition
  assign aluCarryIn = (uword.carryInForce | (uword.carryInUseCond & cond.condCarry))
                      ^ uword.carryInInvert;

  // alu: mode selects logic or arithmetic, four bit function
  always_comb begin
    logic [15:0] a;
    logic [15:0] b;
    logic [15:0] x;
    logic [15:0] y;
    a = aluFirstOperand;
    b = aluSecondOperand;
    x = a;
    y = 16'h0000;
    aluRes  = 16'h0000;
    sumWord = 17'h0_0000;
    sumByte = 9'h000;
    if (uword.aluLogicArithMode) begin
      case (uword.aluFunctionSelect)
        4'h0: aluRes = ~a;
        4'h1: aluRes = ~(a | b);
        4'h2: aluRes = ~a & b;
        4'h3: aluRes = 16'h0000;
        4'h4: aluRes = ~(a & b);
        4'h5: aluRes = ~b;
        4'h6: aluRes = a ^ b;
        4'h7: aluRes = a & ~b;
        4'h8: aluRes = ~a | b;
        4'h9: aluRes = ~(a ^ b);
        4'ha: aluRes = b;
        4'hb: aluRes = a & b;
        4'hc: aluRes = 16'hffff;
        4'hd: aluRes = a | ~b;
        4'he: aluRes = a | b;
        4'hf: aluRes = a;
        default: aluRes = a;
      endcase
    end else begin
      // each arithmetic function is a sum of two terms plus carry in
      case (uword.aluFunctionSelect)
        4'h0: x = a;
        4'h1: x = a | b;
        4'h2: x = a | ~b;
        4'h3: x = 16'hffff;
        4'h4: x = a;
        4'h5: x = a | b;
        4'h6: x = a;
        4'h7: x = a & ~b;
        4'h8: x = a;
        4'h9: x = a;
        4'ha: x = a | ~b;
        4'hb: x = a & b;
        4'hc: x = a;
        4'hd: x = a | b;
        4'he: x = a | ~b;
        4'hf: x = a;
        default: x = a;
      endcase
      case (uword.aluFunctionSelect)
        4'h4: y = a & ~b;
        4'h5: y = a & ~b;
        4'h6: y = ~b;
        4'h7: y = 16'hffff;
        4'h8: y = a & b;
        4'h9: y = b;
        4'ha: y = a & b;
        4'hb: y = 16'hffff;
        4'hc: y = a;
        4'hd: y = a;
        4'he: y = a;
        4'hf: y = 16'hffff;
        default: y = 16'h0000;
      endcase
      // byte carry comes from the same two terms, low eight bits only
      sumWord = {1'b0, x} + {1'b0, y} + {16'h0000, aluCarryIn};
      sumByte = {1'b0, x[7:0]} + {1'b0, y[7:0]} + {8'h00, aluCarryIn};
      aluRes  = sumWord[15:0];
    end
  end

  assign wordCarryOut = uword.aluLogicArithMode ? 1'b0 : sumWord[16];
  assign byteCarryOut = sumByte[8];
  assign aluResultMsb = aluRes[15];

  // carry source selector
  always_comb begin
    case (uword.carrySourceSel)
      POD_CS_WORD: carrySel = wordCarryOut;
      POD_CS_BYTE: carrySel = byteCarryOut;
      POD_CS_MSB:  carrySel = aluResultMsb;
      POD_CS_STAT: carrySel = cond.statusCarryBit;
      default:     carrySel = wordCarryOut;
    endcase
  end

  assign rfWriteOk = uword.regWrite && !uword.regRead;

  // next state of all datapath registers outside the register file
  always_comb begin
    st_d         = st_q;
    st_d.readBus = rdBus;
    st_d.aluOut  = aluRes;
    st_d.err     = uword.regWrite && uword.regRead;
    if (uword.loadB) begin
      st_d.bReg = resultPath;
    end
    if (uword.loadD) begin
      st_d.dReg = aluRes;
    end
    if (uword.loadCarry) begin
      st_d.dCarry = carrySel;
    end
    if (uword.loadAddr) begin
      st_d.addrReg = uword.addressSourceSel ? aluRes : rdBus;
    end
  end

  // state register
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // register file writes from the result path, one entry per cycle
  always_ff @(posedge clock) begin
    if (rfWriteOk) begin
      regFile_q[uword.regAddr] <= resultPath;
    end
  end

  assign readBus     = st_q.readBus;
  assign aluResult   = st_q.aluOut;
  assign bRegOut     = st_q.bReg;
  assign dRegOut     = st_q.dReg;
  assign dCarryOut   = st_q.dCarry;
  assign busAddress  = st_q.addrReg;
  assign accessError = st_q.err;

endmodule : pod_datapath

/* File: pod_pkg.sv */
package pod_pkg;
  localparam int POD_W       = 16;
  localparam int POD_BYTE    = 8;
  localparam int POD_NREG    = 16;
  localparam int POD_AW      = 4;
  // result path select codes
  localparam logic [1:0] POD_DM_RD    = 2'h0;
  localparam logic [1:0] POD_DM_BUS   = 2'h1;
  localparam logic [1:0] POD_DM_DREG  = 2'h2;
  localparam logic [1:0] POD_DM_SHR   = 2'h3;
  // operand low byte select codes
  localparam logic [1:0] POD_BL_LO0   = 2'h0;
  localparam logic [1:0] POD_BL_LO1   = 2'h1;
  localparam logic [1:0] POD_BL_HI    = 2'h2;
  localparam logic [1:0] POD_BL_CON   = 2'h3;
  // operand high byte select codes
  localparam logic [1:0] POD_BH_HI    = 2'h0;
  localparam logic [1:0] POD_BH_SGN   = 2'h1;
  localparam logic [1:0] POD_BH_LO    = 2'h2;
  localparam logic [1:0] POD_BH_CON   = 2'h3;
  // carry source select codes
  localparam logic [1:0] POD_CS_WORD  = 2'h0;
  localparam logic [1:0] POD_CS_BYTE  = 2'h1;
  localparam logic [1:0] POD_CS_MSB   = 2'h2;
  localparam logic [1:0] POD_CS_STAT  = 2'h3;
  // constant source codes
  localparam logic [2:0] POD_K_ONE    = 3'h0;
  localparam logic [2:0] POD_K_TWO    = 3'h1;
  localparam logic [2:0] POD_K_SWADR  = 3'h2;
  localparam logic [2:0] POD_K_TRAP   = 3'h3;
  localparam logic [2:0] POD_K_MASK   = 3'h4;
  localparam logic [2:0] POD_K_COND   = 3'h5;
  localparam logic [2:0] POD_K_EXT    = 3'h6;
  localparam logic [2:0] POD_K_ZERO   = 3'h7;
  localparam logic [15:0] POD_VAL_ONE  = 16'h0001;
  localparam logic [15:0] POD_VAL_TWO  = 16'h0002;
  localparam logic [15:0] POD_VAL_MASK = 16'h00ff;
  // reset values
  localparam logic [15:0] POD_RST_WORD = 16'h0000;
  localparam logic        POD_RST_BIT  = 1'b0;

  // microword fields for one cycle
  typedef struct packed {
    logic [3:0] regAddr;
    logic       regWrite;
    logic       regRead;
    logic       statusRead;
    logic [1:0] resultPathSel;
    logic [1:0] operandLowSel;
    logic [1:0] operandHighSel;
    logic       addressSourceSel;
    logic [1:0] carrySourceSel;
    logic [2:0] constantSel;
    logic       aluLogicArithMode;
    logic [3:0] aluFunctionSelect;
    logic       carryInForce;
    logic       carryInUseCond;
    logic       carryInInvert;
    logic       loadB;
    logic       loadD;
    logic       loadCarry;
    logic       loadAddr;
  } pod_uword_t;

  // machine-side conditions
  typedef struct packed {
    logic [15:0] busData;
    logic [15:0] statusWord;
    logic        statusCarryBit;
    logic        condCarry;
    logic [15:0] switchAddr;
    logic [15:0] trapVector;
    logic [15:0] condConst;
  } pod_cond_t;

  typedef struct packed {
    logic [15:0] bReg;
    logic [15:0] dReg;
    logic        dCarry;
    logic [15:0] addrReg;
    logic [15:0] readBus;
    logic [15:0] aluOut;
    logic        carryOut;
  } pod_state_t;
endpackage : pod_pkg

/* File: pod_seq_model.sv */
`timescale 1ns/1ps
module pod_seq_model
  import pod_pkg::*;
(
  input  wire logic       clock,
  input  wire pod_uword_t nextWord,
  output pod_uword_t      uword
);
  // idle word until the first cycle is issued
  initial uword = '0;
  // a fresh microword every cycle, changed away from the taking edge
  always @(negedge clock) begin
    uword <= nextWord;
  end
endmodule : pod_seq_model

/* File: pod_datapath_sva.sv */
`timescale 1ns/1ps
module pod_datapath_sva
  import pod_pkg::*;
(
  input wire logic        clock,
  input wire logic        reset_n,
  input wire pod_uword_t  uword,
  input wire pod_cond_t   cond,
  input wire logic [15:0] readBus,
  input wire logic [15:0] aluResult,
  input wire logic [15:0] bRegOut,
  input wire logic [15:0] dRegOut,
  input wire logic        dCarryOut,
  input wire logic [15:0] busAddress,
  input wire logic        accessError
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);
  // register file access clash
  clash_flag_a: assert property (uword.regRead && uword.regWrite |=> accessError)
    else $error("read and write together not flagged");
  clash_quiet_a: assert property (!(uword.regRead && uword.regWrite) |=> !accessError)
    else $error("clash flag without a clash");
  // holding register loads, holding and result registers hold
  b_load_a: assert property (uword.loadB && uword.resultPathSel == POD_DM_BUS |=> bRegOut == $past(cond.busData))
    else $error("holding register missed bus data");
  shift_in_a: assert property (uword.loadB && uword.resultPathSel == POD_DM_SHR |=> bRegOut == (($past(dRegOut) >> 1) | {$past(dCarryOut), 15'h0000}))
    else $error("shifted result path wrong");
  b_hold_a: assert property (!uword.loadB |=> $stable(bRegOut))
    else $error("holding register changed unloaded");
  d_hold_a: assert property (!uword.loadD |=> $stable(dRegOut))
    else $error("result register changed unloaded");
  // result and address storage
  d_from_alu_a: assert property (uword.loadD |=> dRegOut == aluResult)
    else $error("result register not from alu");
  addr_alu_a: assert property (uword.loadAddr && uword.addressSourceSel |=> busAddress == aluResult)
    else $error("address not from alu");
  addr_read_a: assert property (uword.loadAddr && !uword.addressSourceSel |=> busAddress == readBus)
    else $error("address not from read bus");
  // carry extension sources, status word on the read bus
  carry_msb_a: assert property (uword.loadCarry && uword.carrySourceSel == POD_CS_MSB |=> dCarryOut == aluResult[15])
    else $error("carry extension not alu msb");
  carry_stat_a: assert property (uword.loadCarry && uword.carrySourceSel == POD_CS_STAT |=> dCarryOut == $past(cond.statusCarryBit))
    else $error("carry extension not status carry");
  status_or_a: assert property (uword.statusRead && !uword.regWrite |=> (readBus & $past(cond.statusWord)) == $past(cond.statusWord))
    else $error("status word missing on read bus");
endmodule : pod_datapath_sva

bind pod_datapath pod_datapath_sva i_pod_datapath_sva (
  .clock(clock), .reset_n(reset_n), .uword(uword), .cond(cond), .readBus(readBus),
  .aluResult(aluResult), .bRegOut(bRegOut), .dRegOut(dRegOut), .dCarryOut(dCarryOut),
  .busAddress(busAddress), .accessError(accessError)
);

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
  import pod_pkg::*;
  typedef struct packed {
    logic [2:0]  k;
    logic [1:0]  lo;
    logic [1:0]  hi;
    logic [15:0] exp;
  } pod_row_t;
  logic        clock = 1'b0;
  logic        reset_n = 1'b0;
  pod_uword_t  nw = '0;
  pod_uword_t  uword;
  pod_cond_t   cond = '0;
  logic [15:0] readBus, aluResult, bRegOut, dRegOut, busAddress;
  logic        dCarryOut, accessError;
  int          err_count = 0;
  int          checks_done = 0;
  pod_uword_t  w;
  pod_row_t    rows [14];

  pod_seq_model i_pod_seq_model (.clock(clock), .nextWord(nw), .uword(uword));
  pod_datapath i_pod_datapath (
    .clock(clock), .reset_n(reset_n), .uword(uword), .cond(cond), .readBus(readBus),
    .aluResult(aluResult), .bRegOut(bRegOut), .dRegOut(dRegOut), .dCarryOut(dCarryOut),
    .busAddress(busAddress), .accessError(accessError)
  );

  // 50 ns clock
  always #25 clock = ~clock;

  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checks_done++;
    if (seen !== want) begin
      err_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : check

  // hand a word to the sequencer; it shows at the next falling edge
  task automatic run(input pod_uword_t uw);
    @(posedge clock);
    nw <= uw;
    @(negedge clock);
  endtask : run

  task automatic stop_test;
    $display("checks %0d errors %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // watchdog against a hang
  initial begin
    #100000;
    err_count++;
    stop_test();
  end

  // operand forms from holding value 4cb1, then constants
  initial begin
    rows = '{'{3'h0, 2'h0, 2'h0, 16'h4cb1}, '{3'h0, 2'h1, 2'h0, 16'h4cb1}, '{3'h0, 2'h0, 2'h1, 16'hffb1},
             '{3'h0, 2'h2, 2'h0, 16'h4c4c}, '{3'h0, 2'h0, 2'h2, 16'hb1b1}, '{3'h0, 2'h2, 2'h2, 16'hb14c},
             '{3'h0, 2'h3, 2'h3, 16'h0001}, '{3'h1, 2'h3, 2'h3, 16'h0002}, '{3'h2, 2'h3, 2'h3, 16'h1a2b},
             '{3'h3, 2'h3, 2'h3, 16'h0034}, '{3'h4, 2'h3, 2'h3, 16'h00ff}, '{3'h5, 2'h3, 2'h3, 16'h0055},
             '{3'h6, 2'h3, 2'h3, 16'hff00}, '{3'h7, 2'h3, 2'h3, 16'h0000}};
    cond.switchAddr = 16'h1a2b;
    cond.trapVector = 16'h0034;
    cond.condConst = 16'h0055;
    repeat (16) @(negedge clock);
    reset_n = 1'b1;
    w = '0;
    w.resultPathSel = POD_DM_BUS;
    w.loadB = 1'b1;
    run(w);
    cond.busData = 16'h4cb1;
    for (int i = 0; i < 14; i++) begin
      w = '0;
      w.constantSel = rows[i].k;
      w.operandLowSel = rows[i].lo;
      w.operandHighSel = rows[i].hi;
      w.aluLogicArithMode = 1'b1;
      w.aluFunctionSelect = 4'ha;
      run(w);
      run('0);
      check(aluResult, rows[i].exp);
    end
    // write two entries, read one back with status word ORed in
    w = '0;
    w.regWrite = 1'b1;
    w.regAddr = 4'h5;
    w.resultPathSel = POD_DM_BUS;
    run(w);
    cond.busData = 16'h1234;
    w.regAddr = 4'h6;
    run(w);
    cond.busData = 16'h00f0;
    w = '0;
    w.regRead = 1'b1;
    w.regAddr = 4'h5;
    w.statusRead = 1'b1;
    run(w);
    cond.statusWord = 16'h0101;
    run('0);
    check(readBus, 16'h1335);
    // first operand passed by the alu into result and address
    w.statusRead = 1'b0;
    w.aluLogicArithMode = 1'b1;
    w.aluFunctionSelect = 4'hf;
    w.loadD = 1'b1;
    w.loadAddr = 1'b1;
    w.addressSourceSel = 1'b1;
    run(w);
    run('0);
    check(aluResult, 16'h1234);
    check(dRegOut, 16'h1234);
    check(busAddress, 16'h1234);
    // read and write together: refused, entry kept
    w = '0;
    w.regRead = 1'b1;
    w.regWrite = 1'b1;
    w.regAddr = 4'h5;
    w.resultPathSel = POD_DM_BUS;
    run(w);
    cond.busData = 16'hffff;
    run('0);
    check({15'h0000, accessError}, 16'h0001);
    check(readBus, 16'h0000);
    w.regWrite = 1'b0;
    w.statusRead = 1'b1;
    w.loadAddr = 1'b1;
    run(w);
    run('0);
    check(readBus, 16'h1335);
    check(busAddress, 16'h1335);
    // status carry into extension, then shift it into bit 15
    w = '0;
    w.loadCarry = 1'b1;
    w.carrySourceSel = POD_CS_STAT;
    run(w);
    cond.statusCarryBit = 1'b1;
    w = '0;
    w.resultPathSel = POD_DM_SHR;
    w.loadB = 1'b1;
    run(w);
    cond.statusCarryBit = 1'b0;
    run('0);
    check({15'h0000, dCarryOut}, 16'h0001);
    check(bRegOut, 16'h891a);
    // alu msb of constant one into extension
    w = '0;
    w.loadCarry = 1'b1;
    w.carrySourceSel = POD_CS_MSB;
    w.aluLogicArithMode = 1'b1;
    w.aluFunctionSelect = 4'ha;
    w.operandLowSel = POD_BL_CON;
    w.operandHighSel = POD_BH_CON;
    run(w);
    run('0);
    check({15'h0000, dCarryOut}, 16'h0000);
    check(bRegOut, 16'h891a);
    // add 00f0 + 00ff with condition carry in: byte carry out, none from bit 15
    cond.condCarry = 1'b1;
    w = '0;
    w.regRead = 1'b1;
    w.regAddr = 4'h6;
    w.constantSel = POD_K_MASK;
    w.operandLowSel = POD_BL_CON;
    w.operandHighSel = POD_BH_CON;
    w.aluFunctionSelect = 4'h9;
    w.carryInUseCond = 1'b1;
    w.loadD = 1'b1;
    w.loadCarry = 1'b1;
    w.carrySourceSel = POD_CS_BYTE;
    run(w);
    run('0);
    check(dRegOut, 16'h01f0);
    check({15'h0000, dCarryOut}, 16'h0001);
    w.carrySourceSel = POD_CS_WORD;
    run(w);
    run('0);
    check({15'h0000, dCarryOut}, 16'h0000);
    // add 1234 + ff00 with carry in inverted to zero: word carry out
    w.regAddr = 4'h5;
    w.constantSel = POD_K_EXT;
    w.carryInInvert = 1'b1;
    run(w);
    run('0);
    check(dRegOut, 16'h1134);
    check({15'h0000, dCarryOut}, 16'h0001);
    // reset in mid-run clears the registers at once
    reset_n = 1'b0;
    #1;
    check({15'h0000, dCarryOut}, 16'h0000);
    check(bRegOut, 16'h0000);
    check(dRegOut, 16'h0000);
    check(busAddress, 16'h0000);
    @(negedge clock);
    reset_n = 1'b1;
    run('0);
    check(bRegOut, 16'h0000);
    stop_test();
  end
endmodule : tb
